// ==== verilog/psft_pkg.sv ====
// constants and types for the power switch fault timers
// assumes a 100 mhz system clock
package psft_pkg;
   localparam int unsigned CLOCK_HZ = 100_000_000;
   // undervoltage blanking and retry wait, in milliseconds
   localparam int unsigned BLANK_MS = 32;
   localparam int unsigned RETRY_MS = 128;
   // surge window and lock-out, in milliseconds
   localparam int unsigned SURGE_MS = 128;
   localparam int unsigned LOCKOUT_MS = 128;
   // cycles of the internal timebase per millisecond
   localparam int unsigned MS_CYCLES = CLOCK_HZ / 1000;
   // tick and millisecond counter widths, and the millisecond counter zero value
   localparam int unsigned TICK_W = 17;
   localparam int unsigned MS_W = 8;
   localparam logic [MS_W-1:0] MS_RESET = 8'h00;
   // break-before-make gap between pass off and shunt on
   localparam int unsigned BBM_CYCLES = 4;
   localparam int unsigned BBM_W = 3;

   typedef enum logic [1:0] {
      PSFT_UV_RUN,
      PSFT_UV_BLANK,
      PSFT_UV_OFF,
      PSFT_UV_TRIAL
   } psft_uv_state_t;

   typedef enum logic [1:0] {
      PSFT_SG_IDLE,
      PSFT_SG_WINDOW,
      PSFT_SG_PRIMARY,
      PSFT_SG_LOCKOUT
   } psft_sg_state_t;

   typedef enum logic [1:0] {
      PSFT_OUT_OFF,
      PSFT_OUT_ON,
      PSFT_OUT_GAP,
      PSFT_OUT_SHUNT
   } psft_out_state_t;
endpackage

// ==== verilog/psft_timebase.sv ====
// millisecond tick generator
// assumes a synchronous active-high reset
`timescale 1ns/100ps
module psft_timebase #(
   parameter int unsigned MS_CYCLES = psft_pkg::MS_CYCLES
) (
   input wire logic clock,
   input wire logic sys_rst,
   output logic ms_tick
);
   typedef struct packed {
      logic [psft_pkg::TICK_W-1:0] count;
      logic tick;
   } psft_tb_t;

   psft_tb_t state;
   psft_tb_t next_state;

   localparam logic [psft_pkg::TICK_W-1:0] LAST =
      psft_pkg::TICK_W'(MS_CYCLES - 1);

   // free-running divider, one pulse per millisecond
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (state.count == LAST) begin
         next_state.count = '0;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign ms_tick = state.tick;
endmodule

// ==== verilog/psft_ms_timer.sv ====
// restartable millisecond down-counter
// assumes a one-cycle ms tick from the timebase
`timescale 1ns/100ps
module psft_ms_timer (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic ms_tick,
   input wire logic load,
   input wire logic [psft_pkg::MS_W-1:0] load_ms,
   output logic expired
);
   typedef struct packed {
      logic [psft_pkg::MS_W-1:0] remain;
      logic done;
   } psft_tm_t;

   psft_tm_t state;
   psft_tm_t next_state;

   // load wins; otherwise count ticks down to zero
   always_comb begin
      next_state = state;
      if (load) begin
         next_state.remain = load_ms;
         next_state.done = 1'b0;
      end else if (!state.done && ms_tick) begin
         // one tick past zero, so a full load_ms always elapses
         if (state.remain == psft_pkg::MS_RESET) begin
            next_state.done = 1'b1;
         end else begin
            next_state.remain = state.remain - 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign expired = state.done;
endmodule

// ==== verilog/psft_top.sv ====
// fault timers of a current-limiting high-side power switch
// assumes comparator and flag inputs already synchronous to clock
//
// Behaviour
// - disconnect only after supply stays below trip for 32 ms
// - after undervoltage disconnect, stay off 128 ms then reapply power
// - still low at reapply: power 32 ms then disconnect again, repeat
// - supply above trip at reapply: return to normal, stay connected
// - every upward crossing of the trip point restarts the blanking
// - no hysteresis; blanking timer alone suppresses chatter
// - pass switch held off while sense input is at or below 0.25V
// - undervoltage disconnect runs independent of the surge window
// - surge window passes current to secondary limit for 128 ms
// - secondary limit applies at once whenever exceeded
// - after surge expiry primary limit holds for whole overload
// - end of limiting starts 128 ms lock-out refusing new surges
// - thermal shutdown ends surge at once, output current to zero
// - after thermal recovery resume with primary limit, not secondary
// - on disable pass off first, then shunt on, never both
`timescale 1ns/100ps
module psft_top #(
   parameter int unsigned MS_CYCLES = psft_pkg::MS_CYCLES,
   parameter int unsigned BLANK_MS = psft_pkg::BLANK_MS,
   parameter int unsigned RETRY_MS = psft_pkg::RETRY_MS,
   parameter int unsigned SURGE_MS = psft_pkg::SURGE_MS,
   parameter int unsigned LOCKOUT_MS = psft_pkg::LOCKOUT_MS
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic supply_low,
   input wire logic sense_above_min,
   input wire logic over_primary,
   input wire logic over_secondary,
   input wire logic thermal_shutdown,
   output logic pass_on,
   output logic shunt_on,
   output logic primary_current_ceiling,
   output logic secondary_current_ceiling,
   output logic surge_active,
   output logic lockout_active,
   output logic uv_disengaged
);
   localparam logic [psft_pkg::MS_W-1:0] BLANK_LD =
      psft_pkg::MS_W'(BLANK_MS);
   localparam logic [psft_pkg::MS_W-1:0] RETRY_LD =
      psft_pkg::MS_W'(RETRY_MS);
   localparam logic [psft_pkg::MS_W-1:0] SURGE_LD =
      psft_pkg::MS_W'(SURGE_MS);
   localparam logic [psft_pkg::MS_W-1:0] LOCK_LD =
      psft_pkg::MS_W'(LOCKOUT_MS);
   localparam logic [psft_pkg::BBM_W-1:0] BBM_LAST =
      psft_pkg::BBM_W'(psft_pkg::BBM_CYCLES - 1);

   typedef struct packed {
      psft_pkg::psft_uv_state_t uv;
      psft_pkg::psft_sg_state_t sg;
      psft_pkg::psft_out_state_t out;
      logic [psft_pkg::BBM_W-1:0] gap;
      logic low_q;
      logic pass;
      logic shunt;
      logic prim;
      logic sec;
      logic surge;
      logic lock;
      logic uv_off;
   } psft_st_t;

   psft_st_t state;
   psft_st_t next_state;

   logic ms_tick;
   logic uv_load;
   logic [psft_pkg::MS_W-1:0] uv_load_ms;
   logic uv_done;
   logic sg_load;
   logic [psft_pkg::MS_W-1:0] sg_load_ms;
   logic sg_done;
   logic up_cross;
   logic want_on;

   ////////////////////////////////////////////////////////////////////
   // timebase and interval timers

   psft_timebase #(.MS_CYCLES(MS_CYCLES)) u_timebase (
      .clock(clock),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick)
   );

   psft_ms_timer u_uv_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick),
      .load(uv_load),
      .load_ms(uv_load_ms),
      .expired(uv_done)
   );

   psft_ms_timer u_sg_timer (
      .clock(clock),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick),
      .load(sg_load),
      .load_ms(sg_load_ms),
      .expired(sg_done)
   );

   // raw comparator, no hysteresis; an upward crossing is low to high
   assign up_cross = state.low_q && !supply_low;

   ////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      next_state = state;
      uv_load = 1'b0;
      uv_load_ms = BLANK_LD;
      sg_load = 1'b0;
      sg_load_ms = SURGE_LD;
      next_state.low_q = supply_low;

      // undervoltage blanking, disengage and retry
      unique case (state.uv)
         psft_pkg::PSFT_UV_RUN: begin
            if (supply_low) begin
               next_state.uv = psft_pkg::PSFT_UV_BLANK;
               uv_load = 1'b1;
            end
         end
         psft_pkg::PSFT_UV_BLANK: begin
            if (!supply_low) begin
               next_state.uv = psft_pkg::PSFT_UV_RUN;
            end else if (uv_done) begin
               next_state.uv = psft_pkg::PSFT_UV_OFF;
               uv_load = 1'b1;
               uv_load_ms = RETRY_LD;
            end
         end
         psft_pkg::PSFT_UV_OFF: begin
            if (uv_done) begin
               next_state.uv = psft_pkg::PSFT_UV_TRIAL;
               uv_load = 1'b1;
            end
         end
         psft_pkg::PSFT_UV_TRIAL: begin
            if (!supply_low || up_cross) begin
               next_state.uv = psft_pkg::PSFT_UV_RUN;
            end else if (uv_done) begin
               next_state.uv = psft_pkg::PSFT_UV_OFF;
               uv_load = 1'b1;
               uv_load_ms = RETRY_LD;
            end
         end
      endcase
      next_state.uv_off = (next_state.uv == psft_pkg::PSFT_UV_OFF);

      // surge window, primary limiting and lock-out
      unique case (state.sg)
         psft_pkg::PSFT_SG_IDLE: begin
            if (over_primary && !thermal_shutdown && state.pass) begin
               next_state.sg = psft_pkg::PSFT_SG_WINDOW;
               sg_load = 1'b1;
            end
         end
         psft_pkg::PSFT_SG_WINDOW: begin
            if (thermal_shutdown) begin
               next_state.sg = psft_pkg::PSFT_SG_PRIMARY;
            end else if (!over_primary) begin
               next_state.sg = psft_pkg::PSFT_SG_LOCKOUT;
               sg_load = 1'b1;
               sg_load_ms = LOCK_LD;
            end else if (sg_done) begin
               next_state.sg = psft_pkg::PSFT_SG_PRIMARY;
            end
         end
         psft_pkg::PSFT_SG_PRIMARY: begin
            if (!over_primary && !thermal_shutdown) begin
               next_state.sg = psft_pkg::PSFT_SG_LOCKOUT;
               sg_load = 1'b1;
               sg_load_ms = LOCK_LD;
            end
         end
         psft_pkg::PSFT_SG_LOCKOUT: begin
            if (over_primary || thermal_shutdown) begin
               next_state.sg = psft_pkg::PSFT_SG_PRIMARY;
            end else if (sg_done) begin
               next_state.sg = psft_pkg::PSFT_SG_IDLE;
            end
         end
      endcase
      next_state.surge = (next_state.sg == psft_pkg::PSFT_SG_WINDOW);
      next_state.lock = (next_state.sg == psft_pkg::PSFT_SG_LOCKOUT);
      // secondary ceiling is always armed; primary outside the window
      next_state.sec = 1'b1;
      next_state.prim = !next_state.surge;

      // pass switch and discharge shunt, break before make
      want_on = enable && sense_above_min && !thermal_shutdown
         && (next_state.uv != psft_pkg::PSFT_UV_OFF);
      unique case (state.out)
         psft_pkg::PSFT_OUT_OFF: begin
            if (want_on) begin
               next_state.out = psft_pkg::PSFT_OUT_ON;
            end else begin
               next_state.out = psft_pkg::PSFT_OUT_GAP;
               next_state.gap = '0;
            end
         end
         psft_pkg::PSFT_OUT_ON: begin
            if (!want_on) begin
               next_state.out = psft_pkg::PSFT_OUT_GAP;
               next_state.gap = '0;
            end
         end
         psft_pkg::PSFT_OUT_GAP: begin
            if (want_on) begin
               next_state.out = psft_pkg::PSFT_OUT_ON;
            end else if (state.gap == BBM_LAST) begin
               next_state.out = psft_pkg::PSFT_OUT_SHUNT;
            end else begin
               next_state.gap = state.gap + 1'b1;
            end
         end
         psft_pkg::PSFT_OUT_SHUNT: begin
            if (want_on) begin
               next_state.out = psft_pkg::PSFT_OUT_GAP;
               next_state.gap = BBM_LAST;
            end
         end
      endcase
      // shunt leaving: one gap cycle before pass turns on
      if (state.out == psft_pkg::PSFT_OUT_GAP && state.gap == BBM_LAST
            && want_on && state.shunt) begin
         next_state.out = psft_pkg::PSFT_OUT_ON;
      end
      next_state.pass = (next_state.out == psft_pkg::PSFT_OUT_ON)
         && !state.shunt;
      next_state.shunt = (next_state.out == psft_pkg::PSFT_OUT_SHUNT)
         && !state.pass;
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state.uv <= psft_pkg::PSFT_UV_RUN;
         state.sg <= psft_pkg::PSFT_SG_IDLE;
         state.out <= psft_pkg::PSFT_OUT_OFF;
         state.gap <= '0;
         state.low_q <= 1'b0;
         state.pass <= 1'b0;
         state.shunt <= 1'b0;
         state.prim <= 1'b1;
         state.sec <= 1'b1;
         state.surge <= 1'b0;
         state.lock <= 1'b0;
         state.uv_off <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs, all straight from the state register

   assign pass_on = state.pass;
   assign shunt_on = state.shunt;
   assign primary_current_ceiling = state.prim;
   assign secondary_current_ceiling = state.sec;
   assign surge_active = state.surge;
   assign lockout_active = state.lock;
   assign uv_disengaged = state.uv_off;
endmodule

// ==== sim/psft_chk.sv ====
// port checker for the power switch fault timers
// assumes one clock domain and a bind onto psft_top
`timescale 1ns/100ps
module psft_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic supply_low,
   input wire logic sense_above_min,
   input wire logic over_primary,
   input wire logic over_secondary,
   input wire logic thermal_shutdown,
   input wire logic pass_on,
   input wire logic shunt_on,
   input wire logic primary_current_ceiling,
   input wire logic secondary_current_ceiling,
   input wire logic surge_active,
   input wire logic lockout_active,
   input wire logic uv_disengaged
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   // output relations
   property p_bbm;
      !(pass_on && shunt_on);
   endproperty
   a_bbm: assert property (p_bbm)
      else $error("pass and shunt both on");
   property p_gap;
      $rose(shunt_on) |-> !$past(pass_on, 4);
   endproperty
   a_gap: assert property (p_gap)
      else $error("shunt on too soon");
   property p_sense;
      !sense_above_min |=> !pass_on;
   endproperty
   a_sense: assert property (p_sense)
      else $error("pass on, sense low");
   property p_therm;
      thermal_shutdown |=> !pass_on && !surge_active;
   endproperty
   a_therm: assert property (p_therm)
      else $error("thermal not obeyed");
   property p_sec;
      secondary_current_ceiling && !(surge_active && primary_current_ceiling);
   endproperty
   a_sec: assert property (p_sec)
      else $error("ceiling state wrong");
   property p_start;
      $rose(surge_active) |-> $past(over_primary) && !$past(lockout_active);
   endproperty
   a_start: assert property (p_start)
      else $error("bad surge start");
   property p_uv;
      uv_disengaged |-> !pass_on;
   endproperty
   a_uv: assert property (p_uv)
      else $error("pass on while disengaged");
   property p_rst;
      $fell(sys_rst) |-> !pass_on && !shunt_on && !surge_active &&
         !lockout_active && !uv_disengaged;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset state wrong");
endmodule
bind psft_top psft_chk chk_u (.*);

// ==== sim/psft_top_tb.sv ====
// self-checking bench for psft_top with short timebase
// assumes the design and checker files compiled before it
`timescale 1ns/100ps
module psft_top_tb;
   logic clock = 0, sys_rst = 1, enable = 0, supply_low = 0;
   logic sense_above_min = 1, over_primary = 0, thermal_shutdown = 0;
   logic over_secondary = 0;
   logic pass_on, shunt_on, prim, sec, surge_active, lockout_active;
   logic uv_disengaged;
   int num_errors = 0, cmp_count = 0, cyc = 0, n;
   typedef struct {logic en, low, sense, th, pass;} psft_row_t;
   psft_row_t rows[8] = '{'{1,0,1,0,1}, '{0,0,1,0,0}, '{1,0,0,0,0},
      '{1,0,1,1,0}, '{1,1,1,0,1}, '{1,0,1,0,1}, '{1,1,1,0,1}, '{1,0,1,0,1}};
   psft_top #(.MS_CYCLES(10), .BLANK_MS(4), .RETRY_MS(6), .SURGE_MS(8),
      .LOCKOUT_MS(5)) dut_u (.clock(clock), .sys_rst(sys_rst),
      .enable(enable), .supply_low(supply_low),
      .sense_above_min(sense_above_min), .over_primary(over_primary),
      .over_secondary(over_secondary), .thermal_shutdown(thermal_shutdown),
      .pass_on(pass_on), .shunt_on(shunt_on),
      .primary_current_ceiling(prim), .secondary_current_ceiling(sec),
      .surge_active(surge_active), .lockout_active(lockout_active),
      .uv_disengaged(uv_disengaged));
   always #5 clock = ~clock;
   ////////////////////////////////////////////////////////////
   // helpers
   task automatic chk(input logic got, input logic exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic rng(input int v, input int lo, input int hi,
         input string m);
      chk(v >= lo && v <= hi, 1'b1, m);
   endtask
   function automatic logic sig(input int s);
      case (s)
         0: return pass_on;
         1: return surge_active;
         2: return uv_disengaged;
         default: return lockout_active;
      endcase
   endfunction
   // count falling edges until a watched output reaches a level
   task automatic wait_sig(input int s, input logic v, input int lim);
      n = 0;
      while (sig(s) !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(negedge clock);
      sys_rst = 0;
      foreach (rows[i]) begin
         enable = rows[i].en;
         supply_low = rows[i].low;
         sense_above_min = rows[i].sense;
         thermal_shutdown = rows[i].th;
         repeat (25) @(negedge clock);
         chk(pass_on, rows[i].pass, "row pass");
         chk(shunt_on, !rows[i].pass, "row shunt");
      end
      $display("table done");
      supply_low = 1;
      wait_sig(2, 1, 80);
      rng(n, 40, 52, "blanking time");
      wait_sig(0, 1, 100);
      rng(n, 50, 74, "retry off time");
      wait_sig(2, 1, 80);
      rng(n, 40, 52, "trial time");
      wait_sig(0, 1, 100);
      rng(n, 50, 74, "second retry off time");
      supply_low = 0;
      repeat (80) @(negedge clock);
      chk(pass_on, 1'b1, "stays connected");
      $display("undervoltage done");
      over_primary = 1;
      repeat (2) @(negedge clock);
      chk(surge_active, 1'b1, "surge starts");
      chk(prim, 1'b0, "primary off in surge");
      over_secondary = 1;
      repeat (2) @(negedge clock);
      chk(sec, 1'b1, "secondary ceiling armed");
      chk(surge_active, 1'b1, "surge kept at second limit");
      over_secondary = 0;
      wait_sig(1, 0, 120);
      rng(n, 76, 92, "surge length");
      repeat (20) @(negedge clock);
      chk(prim, 1'b1, "primary holds");
      over_primary = 0;
      repeat (2) @(negedge clock);
      chk(lockout_active, 1'b1, "lockout starts");
      over_primary = 1;
      repeat (20) @(negedge clock);
      chk(surge_active, 1'b0, "surge refused");
      over_primary = 0;
      repeat (2) @(negedge clock);
      chk(lockout_active, 1'b1, "lockout restarts");
      wait_sig(3, 0, 80);
      rng(n, 48, 60, "lockout length");
      $display("surge done");
      over_primary = 1;
      repeat (3) @(negedge clock);
      chk(surge_active, 1'b1, "surge before thermal");
      thermal_shutdown = 1;
      repeat (2) @(negedge clock);
      chk(surge_active | pass_on, 1'b0, "thermal stop");
      thermal_shutdown = 0;
      repeat (30) @(negedge clock);
      chk(pass_on & prim & !surge_active, 1'b1, "primary after");
      over_primary = 0;
      repeat (2) @(negedge clock);
      wait_sig(3, 0, 80);
      rng(n, 48, 60, "lockout after thermal");
      over_primary = 1;
      repeat (3) @(negedge clock);
      chk(surge_active, 1'b1, "surge open again");
      supply_low = 1;
      wait_sig(2, 1, 80);
      rng(n, 40, 52, "uv during surge");
      chk(surge_active & !pass_on, 1'b1, "disengaged mid surge");
      $display("thermal and surge overlap done");
      over_primary = 0;
      supply_low = 0;
      sys_rst = 1;
      repeat (2) @(negedge clock);
      chk(pass_on | shunt_on | uv_disengaged, 1'b0, "reset clears");
      chk(surge_active | lockout_active, 1'b0, "reset ends surge");
      sys_rst = 0;
      repeat (20) @(negedge clock);
      chk(pass_on, 1'b1, "on after reset");
      $display("reset done");
      tally_and_finish;
   end
endmodule
